/* src/pgm_power_good.sv */
// power-good flag masking: two debounced power-good outputs from flags
// assumes flags arrive asynchronously from protection logic; registers
// are reached over classic wishbone on clk_sys_i
//
// Functional notes
// R1: clearing mask bit 0, 1 or 2 drops the switch, load and local over-voltage flag from the second output.
// R2: clearing mask bit 3 or 4 drops the under-voltage or secondary over-current flag from the second output.
// R3: clearing mask bit 5, 6 or 7 drops the primary over-current flags or the soft-start flag from the second output.
// R4: the first output and its status bit rise only after the debounce time chosen by config bits 7:6.
// R5: the second output and its status bit rise only after the debounce time chosen by config bits 5:4.
// R6: with config bit 3 set, every flag not masked out may move the second output.
// R7: an output falls while any counted flag is active and rises after all stay clear for the debounce time.
`timescale 1ns/1ns
`default_nettype none
module pgm_power_good #(
   parameter int DEB_CYC_0 = pgm_pkg::DEB_CYC_0,
   parameter int DEB_CYC_1 = pgm_pkg::DEB_CYC_1,
   parameter int DEB_CYC_2 = pgm_pkg::DEB_CYC_2,
   parameter int DEB_CYC_3 = pgm_pkg::DEB_CYC_3
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pgm_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [pgm_pkg::WB_DAT_W-1:0] wb_dat_i,
   output logic [pgm_pkg::WB_DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire pgm_pkg::pgm_flag_t flags_i,
   output logic power_good_first_o,
   output logic power_good_second_o,
   output logic irq_o
);
   import pgm_pkg::*;

   // refuse debounce counts the per-output debounce counters cannot serve
   localparam longint DEB_MAX = longint'(1) << DEB_CNT_W;
   localparam bit DEB_LOW = DEB_CYC_0 < 1 || DEB_CYC_1 < 1 ||
      DEB_CYC_2 < 1 || DEB_CYC_3 < 1;
   localparam bit DEB_HIGH = DEB_CYC_0 >= DEB_MAX ||
      DEB_CYC_1 >= DEB_MAX || DEB_CYC_2 >= DEB_MAX ||
      DEB_CYC_3 >= DEB_MAX;

   if (DEB_LOW) begin : g_deb_low
      $error("debounce counts must be at least one cycle");
   end

   if (DEB_HIGH) begin : g_deb_high
      $error("debounce counts exceed the counter width");
   end

   // ------------------------------------------------------------------
   // flag synchroniser
   pgm_flag_t flag_meta_q, flag_sync_q;
   pgm_flag_t flag_meta_d, flag_sync_d;

   always_comb begin
      flag_meta_d = flags_i;
      flag_sync_d = flag_meta_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flag_meta_q <= '0;
         flag_sync_q <= '0;
      end else begin
         flag_meta_q <= flag_meta_d;
         flag_sync_q <= flag_sync_d;
      end
   end

   // ------------------------------------------------------------------
   // bus decode
   logic [7:0] bus_idx;
   logic bus_req;
   logic bus_wr;
   logic wr_deb_cfg, wr_flag_mask, wr_first_mask;
   logic wr_irq_stat, wr_irq_mask, wr_flag_seen;
   logic [7:0] wdata;

   assign bus_idx = wb_adr_i[9:2];
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wdata = wb_dat_i[7:0];

   // write takes effect at the edge where the master sees ack
   assign bus_wr = bus_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   assign wr_deb_cfg = bus_wr & (bus_idx == IDX_DEB_CFG);
   assign wr_flag_mask = bus_wr & (bus_idx == IDX_FLAG_MASK);
   assign wr_first_mask = bus_wr & (bus_idx == IDX_FIRST_MASK);
   assign wr_irq_stat = bus_wr & (bus_idx == IDX_IRQ_STAT);
   assign wr_irq_mask = bus_wr & (bus_idx == IDX_IRQ_MASK);
   assign wr_flag_seen = bus_wr & (bus_idx == IDX_FLAG_SEEN);

   // ------------------------------------------------------------------
   // configuration registers
   logic [7:0] deb_cfg_q, deb_cfg_d;
   pgm_flag_t flag_mask_q, flag_mask_d;
   pgm_flag_t first_mask_q, first_mask_d;

   always_comb begin
      deb_cfg_d = wr_deb_cfg ? wdata : deb_cfg_q;
      flag_mask_d = wr_flag_mask ? wdata : flag_mask_q;
      first_mask_d = wr_first_mask ? wdata : first_mask_q;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         deb_cfg_q <= RST_DEB_CFG;
         flag_mask_q <= RST_FLAG_MASK;
         first_mask_q <= RST_FIRST_MASK;
      end else begin
         deb_cfg_q <= deb_cfg_d;
         flag_mask_q <= flag_mask_d;
         first_mask_q <= first_mask_d;
      end
   end

   // ------------------------------------------------------------------
   // fault evaluation
   pgm_flag_t first_count, second_count;
   logic first_fault, second_fault;
   logic [1:0] first_sel, second_sel;

   always_comb begin
      first_count = flag_sync_q & first_mask_q;
      // a cleared mask bit removes its flag from the second output
      second_count = flag_sync_q & flag_mask_q; // R1 R2 R3
      if (!deb_cfg_q[DEB_ALL_BIT]) begin
         // only flags also counted by the first output move the second
         second_count = second_count & first_mask_q;
      end
      // set: any flag not ignored may move the second output
      first_fault = |first_count;
      second_fault = |second_count; // R6
   end

   assign first_sel = deb_cfg_q[DEB_FIRST_LSB +: 2]; // R4
   assign second_sel = deb_cfg_q[DEB_SECOND_LSB +: 2]; // R5

   logic pg_first, pg_second;

   pgm_pg_debounce #(
      .CNT_W(DEB_CNT_W),
      .CYC_0(DEB_CYC_0),
      .CYC_1(DEB_CYC_1),
      .CYC_2(DEB_CYC_2),
      .CYC_3(DEB_CYC_3)
   ) u_deb_first (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .fault_i(first_fault),
      .sel_i(first_sel),
      .pg_o(pg_first)
   );

   pgm_pg_debounce #(
      .CNT_W(DEB_CNT_W),
      .CYC_0(DEB_CYC_0),
      .CYC_1(DEB_CYC_1),
      .CYC_2(DEB_CYC_2),
      .CYC_3(DEB_CYC_3)
   ) u_deb_second (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .fault_i(second_fault),
      .sel_i(second_sel),
      .pg_o(pg_second)
   );

   assign power_good_first_o = pg_first;
   assign power_good_second_o = pg_second;

   // ------------------------------------------------------------------
   // edge tracking, seen flags and drop cause
   logic pg_first_q, pg_first_d;
   logic pg_second_q, pg_second_d;
   pgm_flag_t seen_q, seen_d;
   pgm_flag_t cause_q, cause_d;
   logic [NUM_IRQ-1:0] irq_event;
   logic [NUM_IRQ-1:0] irq_clr;

   always_comb begin
      pg_first_d = pg_first;
      pg_second_d = pg_second;
      // hardware set wins over software clear
      seen_d = (seen_q & ~(wr_flag_seen ? wdata : 8'h00)) | flag_sync_q;
      cause_d = cause_q;
      if (second_fault && pg_second) begin
         cause_d = second_count; // R7
      end
      irq_event = '0;
      irq_event[IRQ_FIRST_FALL] = pg_first_q & ~pg_first;
      irq_event[IRQ_FIRST_RISE] = ~pg_first_q & pg_first;
      irq_event[IRQ_SECOND_FALL] = pg_second_q & ~pg_second;
      irq_event[IRQ_SECOND_RISE] = ~pg_second_q & pg_second;
      irq_clr = wr_irq_stat ? wdata[NUM_IRQ-1:0] : '0;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pg_first_q <= 1'b0;
         pg_second_q <= 1'b0;
         seen_q <= '0;
         cause_q <= '0;
      end else begin
         pg_first_q <= pg_first_d;
         pg_second_q <= pg_second_d;
         seen_q <= seen_d;
         cause_q <= cause_d;
      end
   end

   logic [NUM_IRQ-1:0] irq_stat, irq_mask;

   pgm_irq #(
      .N(NUM_IRQ)
   ) u_irq (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .event_i(irq_event),
      .clr_i(irq_clr),
      .mask_we_i(wr_irq_mask),
      .mask_wdata_i(wdata[NUM_IRQ-1:0]),
      .status_o(irq_stat),
      .mask_o(irq_mask),
      .irq_o(irq_o)
   );

   // ------------------------------------------------------------------
   // bus answer: ack one cycle after request, data registered with it
   logic ack_q, ack_d;
   logic [WB_DAT_W-1:0] rdata_q, rdata_d;
   logic [7:0] rsel;

   always_comb begin
      case (bus_idx)
         IDX_DEB_CFG: rsel = deb_cfg_q;
         IDX_FLAG_MASK: rsel = flag_mask_q;
         IDX_FIRST_MASK: rsel = first_mask_q;
         IDX_STATE: begin
            rsel = 8'h00;
            rsel[ST_FIRST] = pg_first;
            rsel[ST_SECOND] = pg_second;
         end
         IDX_IRQ_STAT: rsel = {{(8 - NUM_IRQ){1'b0}}, irq_stat};
         IDX_IRQ_MASK: rsel = {{(8 - NUM_IRQ){1'b0}}, irq_mask};
         IDX_FLAG_SEEN: rsel = seen_q;
         IDX_DROP_CAUSE: rsel = cause_q;
         default: rsel = 8'h00;
      endcase
      ack_d = bus_req & ~ack_q;
      rdata_d = rdata_q;
      if (bus_req && !ack_q) begin
         rdata_d = {24'h000000, rsel};
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

endmodule : pgm_power_good
`default_nettype wire

/* src/pgm_pkg.sv */
// constants, register map and types of the power-good flag masking block
// assumes a 25 MHz system clock and a 32-bit classic wishbone register bus
package pgm_pkg;

   localparam int NUM_FLAGS = 8;
   typedef logic [NUM_FLAGS-1:0] pgm_flag_t;

   localparam int REG_W = 8;
   localparam int WB_ADR_W = 10;
   localparam int WB_DAT_W = 32;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_DEB_CFG = 8'h2d;
   localparam logic [7:0] IDX_FLAG_MASK = 8'h7b;
   localparam logic [7:0] IDX_FIRST_MASK = 8'h7c;
   localparam logic [7:0] IDX_STATE = 8'h7d;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h7e;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h7f;
   localparam logic [7:0] IDX_FLAG_SEEN = 8'h7a;
   localparam logic [7:0] IDX_DROP_CAUSE = 8'h79;

   // debounce configuration fields
   localparam int DEB_FIRST_LSB = 6;
   localparam int DEB_SECOND_LSB = 4;
   localparam int DEB_ALL_BIT = 3;

   // values after reset
   localparam logic [7:0] RST_DEB_CFG = 8'h00;
   localparam logic [7:0] RST_FLAG_MASK = 8'hff;
   localparam logic [7:0] RST_FIRST_MASK = 8'hff;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;

   // state register bits
   localparam int ST_FIRST = 0;
   localparam int ST_SECOND = 1;

   // interrupt status bits
   localparam int NUM_IRQ = 4;
   localparam int IRQ_FIRST_FALL = 0;
   localparam int IRQ_FIRST_RISE = 1;
   localparam int IRQ_SECOND_FALL = 2;
   localparam int IRQ_SECOND_RISE = 3;

   // debounce times per code, in microseconds
   localparam longint CLK_HZ = 25000000;
   localparam longint DEB_US_0 = 10;
   localparam longint DEB_US_1 = 1000;
   localparam longint DEB_US_2 = 10000;
   localparam longint DEB_US_3 = 100000;
   localparam int DEB_CYC_0 = int'((DEB_US_0 * CLK_HZ + 999999) / 1000000);
   localparam int DEB_CYC_1 = int'((DEB_US_1 * CLK_HZ + 999999) / 1000000);
   localparam int DEB_CYC_2 = int'((DEB_US_2 * CLK_HZ + 999999) / 1000000);
   localparam int DEB_CYC_3 = int'((DEB_US_3 * CLK_HZ + 999999) / 1000000);
   localparam int DEB_CNT_W = 22;

endpackage : pgm_pkg

/* src/pgm_pg_debounce.sv */
// on-debounce of one power-good output
// assumes fault_i is already synchronous to clk_sys_i
`timescale 1ns/1ns
`default_nettype none
module pgm_pg_debounce #(
   parameter int CNT_W = 22,
   parameter int CYC_0 = 250,
   parameter int CYC_1 = 25000,
   parameter int CYC_2 = 250000,
   parameter int CYC_3 = 2500000
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic fault_i,
   input wire logic [1:0] sel_i,
   output logic pg_o
);
   import pgm_pkg::*;

   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic pg_q, pg_d;
   logic [CNT_W-1:0] limit;

   always_comb begin
      case (sel_i)
         2'h0: limit = CNT_W'(CYC_0);
         2'h1: limit = CNT_W'(CYC_1);
         2'h2: limit = CNT_W'(CYC_2);
         default: limit = CNT_W'(CYC_3);
      endcase
   end

   always_comb begin
      cnt_d = cnt_q;
      pg_d = pg_q;
      if (fault_i) begin
         cnt_d = '0; // R7
         pg_d = 1'b0; // R7
      end else if (!pg_q) begin
         if (cnt_q + CNT_W'(1) >= limit) begin
            pg_d = 1'b1; // R7
         end else begin
            cnt_d = cnt_q + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= '0;
         pg_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pg_q <= pg_d;
      end
   end

   assign pg_o = pg_q;

endmodule : pgm_pg_debounce
`default_nettype wire

/* src/pgm_irq.sv */
// sticky event status, write-one-to-clear, with mask and level interrupt
// assumes event and clear pulses come from logic on clk_sys_i
`timescale 1ns/1ns
`default_nettype none
module pgm_irq #(
   parameter int N = 4
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [N-1:0] event_i,
   input wire logic [N-1:0] clr_i,
   input wire logic mask_we_i,
   input wire logic [N-1:0] mask_wdata_i,
   output logic [N-1:0] status_o,
   output logic [N-1:0] mask_o,
   output logic irq_o
);
   import pgm_pkg::*;

   logic [N-1:0] stat_q, stat_d;
   logic [N-1:0] mask_q, mask_d;
   logic irq_q, irq_d;

   always_comb begin
      // a new event wins over a clear in the same cycle
      stat_d = (stat_q & ~clr_i) | event_i;
      mask_d = mask_we_i ? mask_wdata_i : mask_q;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         stat_q <= '0;
         mask_q <= N'(RST_IRQ_MASK);
         irq_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end

   assign status_o = stat_q;
   assign mask_o = mask_q;
   assign irq_o = irq_q;

endmodule : pgm_irq
`default_nettype wire

/* testbench/pgm_assertions.sv */
// port checks of the power-good block
// assumes binding into pgm_power_good
`timescale 1ns/1ns
`default_nettype none
module pgm_assertions #(
   parameter int DEB_CYC_0 = pgm_pkg::DEB_CYC_0,
   parameter int DEB_CYC_1 = pgm_pkg::DEB_CYC_1,
   parameter int DEB_CYC_2 = pgm_pkg::DEB_CYC_2,
   parameter int DEB_CYC_3 = pgm_pkg::DEB_CYC_3
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pgm_pkg::WB_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [pgm_pkg::WB_DAT_W-1:0] wb_dat_i,
   input wire logic [pgm_pkg::WB_DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire pgm_pkg::pgm_flag_t flags_i,
   input wire logic power_good_first_o,
   input wire logic power_good_second_o,
   input wire logic irq_o
);
   import pgm_pkg::*;
   logic [7:0] fm_q, fk_q, dc_q, c1_q, c2_q;
   pgm_flag_t k2;
   logic wr;
   assign wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   assign k2 = dc_q[DEB_ALL_BIT] ? fm_q : fm_q & fk_q;
   function automatic int deb(input logic [1:0] c);
      return c == 2'h0 ? DEB_CYC_0 : c == 2'h1 ? DEB_CYC_1 :
         c == 2'h2 ? DEB_CYC_2 : DEB_CYC_3;
   endfunction : deb
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fm_q <= RST_FLAG_MASK;
         fk_q <= RST_FIRST_MASK;
         dc_q <= RST_DEB_CFG;
         c1_q <= 8'h00;
         c2_q <= 8'h00;
      end else begin
         if (wr && wb_adr_i[9:2] == IDX_FLAG_MASK) fm_q <= wb_dat_i[7:0];
         if (wr && wb_adr_i[9:2] == IDX_FIRST_MASK) fk_q <= wb_dat_i[7:0];
         if (wr && wb_adr_i[9:2] == IDX_DEB_CFG) dc_q <= wb_dat_i[7:0];
         // cycles the counted flags have been clear at the pins
         c1_q <= |(flags_i & fk_q) ? 8'h00 : c1_q + 8'(c1_q != 8'hff);
         c2_q <= |(flags_i & k2) ? 8'h00 : c2_q + 8'(c2_q != 8'hff);
      end
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_width_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   first_drop_a: assert property (
      (|(flags_i & fk_q)) [*3] |=> !power_good_first_o)
      else $error("first output high with counted flag");
   second_drop_a: assert property (
      (|(flags_i & k2)) [*3] |=> !power_good_second_o)
      else $error("second output high with counted flag");
   first_wait_a: assert property (
      $rose(power_good_first_o) |-> c1_q >= deb(dc_q[7:6]))
      else $error("first output rose before debounce");
   second_wait_a: assert property (
      $rose(power_good_second_o) |-> c2_q >= deb(dc_q[5:4]))
      else $error("second output rose before debounce");
   irq_clear_a: assert property ($fell(irq_o) |-> $past(wr) || $past(wr, 2))
      else $error("irq fell without a write");
   reset_low_a: assert property (
      $rose(rst_n_i) |-> !power_good_first_o && !power_good_second_o)
      else $error("power good high after reset");
endmodule : pgm_assertions
bind pgm_power_good pgm_assertions #(.DEB_CYC_0(DEB_CYC_0),
   .DEB_CYC_1(DEB_CYC_1), .DEB_CYC_2(DEB_CYC_2), .DEB_CYC_3(DEB_CYC_3))
   i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .flags_i(flags_i), .irq_o(irq_o),
   .power_good_first_o(power_good_first_o),
   .power_good_second_o(power_good_second_o));
`default_nettype wire

/* testbench/pgm_sys_watch.sv */
// system-side watcher counting drops of the second power-good pin
// assumes the pin is a level on clk_sys_i
`timescale 1ns/1ns
`default_nettype none
module pgm_sys_watch (
   input wire logic clk_sys_i,
   input wire logic power_good_second_i,
   output var int drops_o
);
   logic last_q = 1'b0;
   initial drops_o = 0;
   always @(posedge clk_sys_i) begin
      if (last_q === 1'b1 && power_good_second_i === 1'b0) drops_o <= drops_o + 1;
      last_q <= power_good_second_i;
   end
endmodule : pgm_sys_watch
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench of the power-good block
// assumes debounce counts shortened to 2, 4, 8 and 16 cycles
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pgm_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [9:0] adr = 10'h0;
   logic [3:0] sel = 4'h1;
   logic [31:0] wdat = 32'h0, rdat;
   logic ack, pg1, pg2, irq;
   logic [7:0] rd;
   pgm_flag_t flags = 8'h00;
   int bad_count = 0, checked = 0, drops, n, t1, t2;
   int dl [4] = '{2, 4, 8, 16};
   logic [7:0] rows [17][5];
   always #20 clk = ~clk;
   pgm_power_good #(.DEB_CYC_0(2), .DEB_CYC_1(4), .DEB_CYC_2(8),
      .DEB_CYC_3(16)) i_dut (.clk_sys_i(clk), .rst_n_i(rst_n),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .flags_i(flags), .power_good_first_o(pg1),
      .power_good_second_o(pg2), .irq_o(irq));
   pgm_sys_watch i_mon (.clk_sys_i(clk), .power_good_second_i(pg2),
      .drops_o(drops));
   task automatic bus(input logic w, input logic [7:0] i,
         input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'h0};
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic rng(input int got, input int lo, input int hi);
      checked++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("Error %0t: count %0d not %0d..%0d", $time, got, lo, hi);
      end
   endtask : rng
   task automatic complete_run();
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   initial begin
      // rows: flag mask, config, first mask, flags, {first, second}
      for (int i = 0; i < 8; i++) begin
         rows[i] = '{~(8'h01 << i), 8'h08, 8'hff, 8'h01 << i, 8'h01};
         rows[i+8] = '{8'hff, 8'h08, ~(8'h01 << i), 8'h01 << i, 8'h02};
      end
      rows[16] = '{8'hff, 8'h00, 8'hfe, 8'h01, 8'h03};
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      foreach (rows[r]) begin
         bus(1'b1, IDX_FLAG_MASK, rows[r][0]);
         bus(1'b1, IDX_DEB_CFG, rows[r][1]);
         bus(1'b1, IDX_FIRST_MASK, rows[r][2]);
         flags <= rows[r][3];
         repeat (30) @(posedge clk);
         chk({6'h0, pg1, pg2}, rows[r][4]);
      end
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, IDX_DEB_CFG, {c[1:0], 2'(3 - c), 4'h8});
         flags <= 8'hff;
         repeat (8) @(posedge clk);
         flags <= 8'h00;
         t1 = 0;
         t2 = 0;
         for (int k = 1; k < 40; k++) begin
            @(posedge clk);
            if (pg1 === 1'b1 && t1 == 0) t1 = k;
            if (pg2 === 1'b1 && t2 == 0) t2 = k;
         end
         rng(t1, dl[c], dl[c] + 5);
         rng(t2, dl[3-c], dl[3-c] + 5);
      end
      bus(1'b1, IDX_IRQ_STAT, 8'h0f);
      bus(1'b1, IDX_IRQ_MASK, 8'h04);
      n = drops;
      flags <= 8'h08;
      repeat (8) @(posedge clk);
      chk({7'h0, irq}, 8'h01);
      rng(drops - n, 1, 1);
      bus(1'b0, IDX_IRQ_STAT, 8'h00);
      chk(rd, 8'h05);
      bus(1'b0, IDX_DROP_CAUSE, 8'h00);
      chk(rd, 8'h08);
      bus(1'b1, IDX_FLAG_SEEN, 8'hff);
      bus(1'b0, IDX_FLAG_SEEN, 8'h00);
      chk(rd, 8'h08);
      bus(1'b1, IDX_IRQ_MASK, 8'h08);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      bus(1'b1, IDX_IRQ_MASK, 8'h04);
      bus(1'b1, IDX_IRQ_STAT, 8'h04);
      repeat (2) @(posedge clk);
      chk({7'h0, irq}, 8'h00);
      sel <= 4'h0;
      bus(1'b1, IDX_FLAG_MASK, 8'h00);
      sel <= 4'h1;
      bus(1'b0, IDX_FLAG_MASK, 8'h00);
      chk(rd, 8'hff);
      flags <= 8'h00;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      chk({6'h0, pg1, pg2}, 8'h00);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, IDX_DEB_CFG, 8'h00);
      chk(rd, RST_DEB_CFG);
      bus(1'b0, IDX_FIRST_MASK, 8'h00);
      chk(rd, RST_FIRST_MASK);
      bus(1'b0, IDX_IRQ_MASK, 8'h00);
      chk(rd, RST_IRQ_MASK);
      bus(1'b1, 8'h10, 8'h5a);
      bus(1'b0, 8'h10, 8'h00);
      chk(rd, 8'h00);
      repeat (30) @(posedge clk);
      bus(1'b0, IDX_STATE, 8'h00);
      chk(rd, 8'h03);
      complete_run();
   end
endmodule : tb
`default_nettype wire
